// ### dv/srm_bus_master.sv
// processor core model: one intermodule bus transfer per task call
// assumes the caller hands it aligned addresses only
`timescale 1ns/1ps
`default_nettype none
module srm_bus_master
  import srm_pkg::*;
(
  input wire logic mclk, // clock
  output var srm_pkg::srm_ib_req_t ib_req, // request to the ram
  input wire srm_pkg::srm_ib_rsp_t ib_rsp // answer from the ram
);
  initial ib_req = '0;
  // ****************
  // transfer
  // ****************
  // request held until ack or a bus time-out; word and long stay even
  task automatic xfer(input logic [23:0] a, input logic [1:0] sz, input logic r, s, p,
    input logic [31:0] wd, output logic [31:0] rd, output logic got);
    int n;
    @(posedge mclk);
    ib_req <= '{1'b1, a, sz, r, s, p, wd};
    got = 1'b0;
    for (n = 0; n < 12 && !got; n++)
    begin
      @(posedge mclk);
      got = (ib_rsp.ack === 1'b1);
    end
    rd = ib_rsp.rdata;
    ib_req.valid <= 1'b0;
  endtask
endmodule // srm_bus_master
`default_nettype wire

// ### dv/srm_standby_ram_assertions.sv
// checker for the standby ram bus and coprocessor ports
// assumes mclk with synchronous active-low reset_n
`timescale 1ns/1ps
`default_nettype none
module srm_chk
  import srm_pkg::*;
(
  input wire logic mclk, // clock
  input wire logic reset_n, // reset
  input wire logic module_map_select, // block select
  input wire logic standby_supply, // standby pin
  input wire srm_pkg::srm_ib_req_t ib_req, // bus request
  input wire srm_pkg::srm_ib_rsp_t ib_rsp, // bus answer
  input wire logic emul_mode, // emulation
  input wire srm_pkg::srm_tc_req_t tc_req, // coprocessor request
  input wire srm_pkg::srm_tc_rsp_t tc_rsp // coprocessor answer
);
  logic [3:0] emul_n;
  logic [3:0] stby_n;
  logic reg_hit;
  // ****************
  // run counters
  // ****************
  // saturating, so long stretches never wrap back into the legal window
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !emul_mode) emul_n <= 4'h0;
    else if (emul_n != 4'hf) emul_n <= emul_n + 4'h1;
  end
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !standby_supply) stby_n <= 4'h0;
    else if (stby_n != 4'hf) stby_n <= stby_n + 4'h1;
  end
  assign reg_hit = ib_req.addr[23:3] ==
    (module_map_select ? REG_BLK_HI[23:3] : REG_BLK_LO[23:3]);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_ack_gap: assert property (ib_rsp.ack |=> !ib_rsp.ack [*2])
    else $error("ack not a lone pulse");
  chk_short_wait: assert property ($rose(ib_req.valid) |-> !ib_rsp.ack [*3])
    else $error("ack too early");
  chk_long_wait: assert property ($rose(ib_req.valid) && ib_req.transfer_size == SZ_LONG
    |-> !ib_rsp.ack [*5])
    else $error("long ack too early");
  chk_reg_super: assert property (ib_rsp.ack && reg_hit |-> ib_req.supv && !ib_req.prog)
    else $error("register acked outside supervisor data");
  chk_emul_block: assert property (ib_rsp.ack |-> emul_n < 4'h6)
    else $error("ack during emulation");
  chk_stby_block: assert property (ib_rsp.ack && !reg_hit |-> stby_n < 4'hc)
    else $error("array ack on standby");
  chk_tc_answer: assert property (tc_req.rd && emul_mode |-> ##[2:3] tc_rsp.valid)
    else $error("coprocessor read unanswered");
  chk_tc_gate: assert property (tc_rsp.valid |-> ($past(tc_req.rd, 2) && $past(emul_mode, 2))
    || ($past(tc_req.rd, 3) && $past(emul_mode, 3)))
    else $error("coprocessor answer without emulation");
  // a long transfer parks its first word in the upper half before its ack
  chk_rdata_hold: assert property (!ib_rsp.ack
    && !(ib_req.valid && ib_req.transfer_size == SZ_LONG) |-> $stable(ib_rsp.rdata))
    else $error("read data moved without ack");
  chk_reset_idle: assert property ($rose(reset_n) |-> !ib_rsp.ack [*3])
    else $error("ack right after reset");
  cover property (ib_rsp.ack && ib_req.transfer_size == SZ_LONG);
  cover property (ib_rsp.ack && reg_hit);
  cover property (tc_rsp.valid);
endmodule // srm_chk
bind srm_standby_ram srm_chk chk_i (.mclk, .reset_n, .module_map_select, .standby_supply,
  .ib_req, .ib_rsp, .emul_mode, .tc_req, .tc_rsp);
`default_nettype wire

// ### dv/testbench.sv
// self-checking bench for the standby ram controller
// assumes the bus master model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import srm_pkg::*;
  localparam logic [23:0] RB = REG_BLK_LO;
  localparam logic [23:0] AB = 24'h123000;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic module_map_select = 1'b0;
  logic standby_supply = 1'b0;
  logic emul_mode = 1'b0;
  srm_tc_req_t tc_req = '0;
  srm_ib_req_t ib_req;
  srm_ib_rsp_t ib_rsp;
  srm_tc_rsp_t tc_rsp;
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] d;
  logic g;
  always #5 mclk = ~mclk;
  srm_standby_ram uut (.mclk, .reset_n, .module_map_select, .standby_supply,
    .ib_req, .ib_rsp, .emul_mode, .tc_req, .tc_rsp);
  srm_bus_master bm (.mclk, .ib_req, .ib_rsp);
  // ****************
  // helpers
  // ****************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (fails == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic xp(input logic [23:0] a, input logic [1:0] sz, input logic r, s, p,
    input logic [31:0] wd, input logic eg, input logic [31:0] ed);
    bm.xfer(a, sz, r, s, p, wd, d, g);
    check({31'h0, g}, {31'h0, eg});
    if (r && eg) check(d, ed);
  endtask
  task automatic wr(input logic [23:0] a, input logic [1:0] sz, input logic [31:0] wd);
    xp(a, sz, 1'b0, 1'b1, 1'b0, wd, 1'b1, 32'h0);
  endtask
  task automatic rd(input logic [23:0] a, input logic [1:0] sz, input logic [31:0] ed);
    xp(a, sz, 1'b1, 1'b1, 1'b0, 32'h0, 1'b1, ed);
  endtask
  task automatic no(input logic [23:0] a, input logic s, input logic p);
    xp(a, SZ_WORD, 1'b1, s, p, 32'h0, 1'b0, 32'h0);
  endtask
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
  endtask
  task automatic setup;
    wr(RB + 24'h4, SZ_WORD, 32'h1230);
    wr(RB, SZ_WORD, 32'h0100);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_regs;
    rd(RB, SZ_WORD, 32'h8100);
    rd(RB + 24'h4, SZ_WORD, {16'h0, BAR_RESET});
    wr(RB + 24'h6, SZ_WORD, 32'hffff);
    rd(RB + 24'h6, SZ_WORD, 32'h0);
    rd(RB + 24'h2, SZ_WORD, 32'h0);
    no(RB, 1'b0, 1'b0);
    no(RB, 1'b1, 1'b1);
    module_map_select <= 1'b1;
    rd(REG_BLK_HI, SZ_WORD, 32'h8100);
    no(RB, 1'b1, 1'b0);
    module_map_select <= 1'b0;
  endtask
  task automatic t_base;
    wr(RB + 24'h4, SZ_WORD, 32'h1230);
    rd(RB + 24'h4, SZ_WORD, 32'h1230);
    no(AB, 1'b1, 1'b0);
    wr(RB, SZ_WORD, 32'h0100);
    wr(AB + 24'h2, SZ_WORD, 32'hbeef);
    rd(AB + 24'h2, SZ_WORD, 32'hbeef);
    no(AB + 24'h2, 1'b0, 1'b0);
    wr(RB + 24'h4, SZ_WORD, 32'h4560);
    rd(RB + 24'h4, SZ_WORD, 32'h1230);
    rd(AB + 24'h3, SZ_BYTE, 32'hef);
    rd(AB + 24'h2, SZ_BYTE, 32'hbe);
    no(AB + 24'h1000, 1'b1, 1'b0);
    wr(AB + 24'h4, SZ_LONG, 32'h11223344);
    rd(AB + 24'h4, SZ_LONG, 32'h11223344);
    rd(AB + 24'h6, SZ_WORD, 32'h3344);
    wr(RB, SZ_WORD, 32'h0);
    xp(AB + 24'h2, SZ_WORD, 1'b1, 1'b0, 1'b1, 32'h0, 1'b1, 32'hbeef);
    wr(RB, SZ_WORD, 32'h8000);
    no(AB + 24'h2, 1'b1, 1'b0);
    wr(RB, SZ_WORD, 32'h0);
    rd(AB + 24'h2, SZ_WORD, 32'hbeef);
  endtask
  task automatic t_stby;
    standby_supply <= 1'b1;
    repeat (8) @(posedge mclk);
    no(AB + 24'h2, 1'b1, 1'b0);
    standby_supply <= 1'b0;
    repeat (8) @(posedge mclk);
    rd(AB + 24'h2, SZ_WORD, 32'hbeef);
  endtask
  task automatic t_emul;
    emul_mode <= 1'b1;
    @(posedge mclk);
    no(RB, 1'b1, 1'b0);
    no(AB + 24'h2, 1'b1, 1'b0);
    tc_req <= '{1'b1, 10'h001};
    @(posedge mclk);
    tc_req.rd <= 1'b0;
    repeat (4) @(posedge mclk);
    check({16'h0, tc_rsp.data}, 32'hbeef);
    emul_mode <= 1'b0;
    tc_req <= '{1'b1, 10'h002};
    @(posedge mclk);
    tc_req.rd <= 1'b0;
    repeat (4) @(posedge mclk);
    check({16'h0, tc_rsp.data}, 32'hbeef);
  endtask
  task automatic t_lock;
    do_reset;
    wr(RB + 24'h4, SZ_BYTE, 32'h12);
    wr(RB + 24'h4, SZ_WORD, 32'h5670);
    bm.xfer(RB + 24'h4, SZ_WORD, 1'b1, 1'b1, 1'b0, 32'h0, d, g);
    check({24'h0, d[15:8]}, 32'h12);
    do_reset;
    wr(RB + 24'h4, SZ_WORD, 32'h7ff0);
    rd(RB + 24'h4, SZ_WORD, 32'h7ff1);
  endtask
  task automatic t_rst_long;
    do_reset;
    setup;
    wr(AB + 24'h8, SZ_LONG, 32'h55556666);
    // reset lands in the first word, so only that word may be stored
    fork
      wr(AB + 24'h8, SZ_LONG, 32'haaaabbbb);
      begin
        repeat (2) @(posedge mclk);
        do_reset;
      end
    join
    setup;
    rd(AB + 24'h8, SZ_LONG, 32'haaaa6666);
  endtask
  initial
  begin
    #50us;
    fails++;
    wrap_up;
  end
  initial
  begin
    do_reset;
    t_regs;
    t_base;
    t_stby;
    t_emul;
    t_lock;
    t_rst_long;
    wrap_up;
  end
endmodule // testbench
`default_nettype wire

// ### logic/srm_array.sv
// flip-flop storage for the 2-Kbyte array, organised as 16-bit words
// assumes the caller muxes one address and gates the byte-lane writes
`timescale 1ns/1ps
`default_nettype none
module srm_array #(
  parameter int WORDS = srm_pkg::RAM_WORDS,
  parameter int IDX_W = srm_pkg::RAM_IDX_W
) (
  input wire logic mclk, // system clock
  input wire logic [IDX_W-1:0] idx, // word index
  input wire logic we_hi, // write upper byte
  input wire logic we_lo, // write lower byte
  input wire logic [15:0] wdata, // write word
  output logic [15:0] rdata // registered read word
);
  logic [15:0] mem [WORDS];

  // contents have no reset: they survive reset and stop mode
  always_ff @(posedge mclk)
  begin
    if (we_hi)
    begin
      mem[idx][15:8] <= wdata[15:8];
    end
    if (we_lo)
    begin
      mem[idx][7:0] <= wdata[7:0];
    end
    rdata <= mem[idx];
  end
endmodule // srm_array
`default_nettype wire

// ### logic/srm_pkg.sv
// shared constants and carrier types for the standby ram controller
// assumes one 100 MHz system clock and a 24-bit intermodule bus address
package srm_pkg;

  // ********************************************************************
  // geometry and address map
  // ********************************************************************
  localparam int ADDR_W = 24;
  localparam int RAM_WORDS = 1024;
  localparam int RAM_IDX_W = 10;
  localparam logic [23:0] REG_BLK_LO = 24'h7ffb00;
  localparam logic [23:0] REG_BLK_HI = 24'hfffb00;
  localparam logic [2:0] OFS_MCR = 3'h0;
  localparam logic [2:0] OFS_TST = 3'h2;
  localparam logic [2:0] OFS_BAR = 3'h4;
  localparam logic [23:0] NEXT_WORD = 24'h000002;

  // ********************************************************************
  // register fields and reset values
  // ********************************************************************
  localparam int MCR_STOP_BIT = 15;
  localparam int MCR_PRIV_BIT = 8;
  localparam logic [15:0] MCR_WR_MASK = 16'h8100;
  localparam logic [15:0] MCR_RESET = 16'h8100;
  localparam int BAR_DS_BIT = 0;
  localparam int BAR_BASE_LSB = 4;
  localparam logic [15:0] BAR_RESET = 16'h0001;

  // ********************************************************************
  // transfer size codes
  // ********************************************************************
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_TRIPLE = 2'h3;

  typedef struct packed {
    logic valid;
    logic [23:0] addr;
    logic [1:0] transfer_size;
    logic rd;
    logic supv;
    logic prog;
    logic [31:0] wdata;
  } srm_ib_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } srm_ib_rsp_t;

  typedef struct packed {
    logic rd;
    logic [9:0] waddr;
  } srm_tc_req_t;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } srm_tc_rsp_t;

  typedef enum logic [1:0] {
    SRM_IDLE = 2'b00,
    SRM_PH_A = 2'b01,
    SRM_PH_B = 2'b10
  } srm_state_t;

endpackage

// ### logic/srm_standby_ram.sv
// standby ram module: bus decode, control registers and array access
// assumes one 100 MHz clock mclk with synchronous active-low reset_n;
// standby_supply comes from a pin, all other inputs share mclk
//
// Overview of operation
// - 2-Kbyte array placed on any 4-Kbyte aligned boundary, repeated in both halves.
// - array answers both program and data space accesses.
// - control registers live only in supervisor data space.
// - register block base chosen by module_map_select between two addresses.
// - eight-byte register block; holes read zero, writes ignored.
// - base bits 15..4 compared with address 23..12; low bits pick location.
// - base register bit 0 is array disable: 0 active, 1 disabled.
// - disabled after reset or on overlap; valid base write enables array.
// - base register takes only the first write after reset, then locks.
// - privilege field picks supervisor-only or any; ignored users decode outside.
// - byte or word takes two clocks; long word takes two bus cycles.
// - array refuses bus access while on standby supply.
// - stop bit enters stop: contents kept, accesses refused.
// - stop written only by supervisor, set by reset, cleared to leave.
// - reset sets stop, supervisor-only, clears base and lock, disables array.
// - reset mid access finishes it; long stops after first word if early.
// - timer coprocessor selects emulation and reads array on its own bus.
// - emulation blocks normal bus access and neutralises control registers.
// - outside emulation the coprocessor has no path to the array.
`timescale 1ns/1ps
`default_nettype none
module srm_standby_ram
  import srm_pkg::*;
#(
  parameter int WORDS = RAM_WORDS
) (
  input wire logic mclk, // system clock
  input wire logic reset_n, // synchronous reset, active low
  input wire logic module_map_select, // selects upper register block address
  input wire logic standby_supply, // array running from standby power
  input wire srm_pkg::srm_ib_req_t ib_req, // intermodule bus request
  output srm_pkg::srm_ib_rsp_t ib_rsp, // intermodule bus answer
  input wire logic emul_mode, // coprocessor selects emulation
  input wire srm_pkg::srm_tc_req_t tc_req, // coprocessor read request
  output srm_pkg::srm_tc_rsp_t tc_rsp // coprocessor read answer
);
  import srm_pkg::*;

  // the word index is address bits 10..1, so only the documented depth fits
  if (WORDS != RAM_WORDS)
  begin : g_bad_depth
    $error("srm_standby_ram: WORDS must equal the 2-Kbyte array depth");
  end

  // ********************************************************************
  // helpers
  // ********************************************************************
  function automatic logic [23:0] blk_base(input logic mm);
    return mm ? REG_BLK_HI : REG_BLK_LO;
  endfunction

  function automatic logic in_block(input logic [23:0] a, input logic mm);
    logic [23:0] b;
    b = blk_base(mm);
    return a[23:3] == b[23:3];
  endfunction

  function automatic logic base_match(input logic [23:0] a, input logic [11:0] base);
    return a[23:12] == base;
  endfunction

  // ********************************************************************
  // standby indication synchroniser
  // ********************************************************************
  logic sb_s1_q, sb_s2_q, sb_s3_q, standby_q;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      sb_s1_q <= 1'b0;
      sb_s2_q <= 1'b0;
      sb_s3_q <= 1'b0;
      standby_q <= 1'b0;
    end
    else
    begin
      sb_s1_q <= standby_supply;
      sb_s2_q <= sb_s1_q;
      sb_s3_q <= sb_s2_q;
      if (sb_s2_q == sb_s3_q)
      begin
        standby_q <= sb_s3_q;
      end
    end
  end

  // ********************************************************************
  // decode
  // ********************************************************************
  srm_state_t state_q;
  srm_ib_req_t req_q;
  logic is_reg_q, second_q, early_q, ack_q;
  logic [31:0] rdata_q;
  logic [15:0] mcr_q, bar_q;
  logic bar_lock_q;
  logic stop_w, priv_sup_w, ds_w;
  logic size_ok, reg_hit, arr_hit, take;

  assign stop_w = mcr_q[MCR_STOP_BIT];
  assign priv_sup_w = mcr_q[MCR_PRIV_BIT];
  assign ds_w = bar_q[BAR_DS_BIT];

  // misaligned or three-byte transfers are simply left unclaimed
  assign size_ok = (ib_req.transfer_size == SZ_BYTE) ||
                   (!ib_req.addr[0] && ib_req.transfer_size != SZ_TRIPLE);
  assign reg_hit = !emul_mode && size_ok && ib_req.supv && !ib_req.prog &&
                   in_block(ib_req.addr, module_map_select);
  assign arr_hit = !emul_mode && !standby_q && !stop_w && !ds_w &&
                   (ib_req.supv || !priv_sup_w) && size_ok && !reg_hit &&
                   base_match(ib_req.addr, bar_q[15:BAR_BASE_LSB]);
  assign take = ib_req.valid && reset_n && state_q == SRM_IDLE && !ack_q &&
                (reg_hit || arr_hit);

  // ********************************************************************
  // current word of the transfer
  // ********************************************************************
  logic [23:0] cur_a;
  logic is_long, is_byte, finish_now;
  logic [15:0] cur_wd, reg_rd, word_rd, arr_rd;
  logic [7:0] byte_rd;

  assign is_long = req_q.transfer_size == SZ_LONG;
  assign is_byte = req_q.transfer_size == SZ_BYTE;
  assign cur_a = second_q ? 24'(req_q.addr + NEXT_WORD) : req_q.addr;
  // a reset seen during the first word of a long cuts it to one word
  assign finish_now = !is_long || second_q || early_q || !reset_n;

  always_comb
  begin
    if (is_byte)
    begin
      cur_wd = {req_q.wdata[7:0], req_q.wdata[7:0]};
    end
    else if (is_long && !second_q)
    begin
      cur_wd = req_q.wdata[31:16];
    end
    else
    begin
      cur_wd = req_q.wdata[15:0];
    end
  end

  always_comb
  begin
    case (cur_a[2:0] & 3'h6)
      OFS_MCR: reg_rd = mcr_q & MCR_WR_MASK;
      OFS_BAR: reg_rd = bar_q;
      default: reg_rd = 16'h0000;
    endcase
  end

  assign word_rd = is_reg_q ? reg_rd : arr_rd;
  assign byte_rd = cur_a[0] ? word_rd[7:0] : word_rd[15:8];

  // ********************************************************************
  // bus cycle sequencer
  // ********************************************************************
  // the sequencer ignores reset while busy so that in-flight accesses end
  always_ff @(posedge mclk)
  begin
    case (state_q)
      SRM_IDLE:
      begin
        if (take)
        begin
          state_q <= SRM_PH_A;
        end
      end
      SRM_PH_A:
      begin
        state_q <= SRM_PH_B;
      end
      SRM_PH_B:
      begin
        if (finish_now)
        begin
          state_q <= SRM_IDLE;
        end
        else
        begin
          state_q <= SRM_PH_A;
        end
      end
      default:
      begin
        state_q <= SRM_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (take)
    begin
      req_q <= ib_req;
      is_reg_q <= reg_hit;
      second_q <= 1'b0;
      early_q <= 1'b0;
    end
    else if (state_q == SRM_PH_B && !finish_now)
    begin
      second_q <= 1'b1;
    end
    else if (state_q != SRM_IDLE && !second_q && !reset_n)
    begin
      early_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n && state_q == SRM_IDLE)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end
    else if (state_q == SRM_PH_B)
    begin
      ack_q <= finish_now;
      if (is_long && !second_q)
      begin
        rdata_q <= {word_rd, 16'h0000};
      end
      else if (is_long)
      begin
        rdata_q <= {rdata_q[31:16], word_rd};
      end
      else if (is_byte)
      begin
        rdata_q <= {24'h000000, byte_rd};
      end
      else
      begin
        rdata_q <= {16'h0000, word_rd};
      end
    end
    else
    begin
      ack_q <= 1'b0;
    end
  end

  assign ib_rsp.ack = ack_q;
  assign ib_rsp.rdata = rdata_q;

  // ********************************************************************
  // control registers
  // ********************************************************************
  logic reg_wr, wr_hi, wr_lo;
  logic [15:0] bar_new;
  logic overlap;

  assign reg_wr = state_q == SRM_PH_B && is_reg_q && !req_q.rd && !emul_mode;
  assign wr_hi = !is_byte || !cur_a[0];
  assign wr_lo = !is_byte || cur_a[0];
  assign bar_new = {wr_hi ? cur_wd[15:8] : bar_q[15:8], wr_lo ? cur_wd[7:0] : bar_q[7:0]};
  assign overlap = base_match(blk_base(module_map_select), bar_new[15:BAR_BASE_LSB]);

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      mcr_q <= MCR_RESET;
    end
    else if (reg_wr && (cur_a[2:0] & 3'h6) == OFS_MCR && wr_hi)
    begin
      mcr_q <= cur_wd & MCR_WR_MASK;
    end
  end

  // a half write still locks, so the other half can no longer change
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      bar_q <= BAR_RESET;
      bar_lock_q <= 1'b0;
    end
    else if (reg_wr && (cur_a[2:0] & 3'h6) == OFS_BAR && !bar_lock_q)
    begin
      bar_lock_q <= 1'b1;
      bar_q <= {bar_new[15:BAR_BASE_LSB], 3'h0, overlap};
    end
  end

  // ********************************************************************
  // array port and coprocessor path
  // ********************************************************************
  logic [RAM_IDX_W-1:0] arr_idx;
  logic arr_we, tc_rd_d1_q;
  srm_tc_rsp_t tc_q;

  assign arr_we = state_q == SRM_PH_B && !is_reg_q && !req_q.rd && !emul_mode;
  assign arr_idx = emul_mode ? tc_req.waddr : cur_a[RAM_IDX_W:1];

  srm_array #(
    .WORDS(WORDS),
    .IDX_W(RAM_IDX_W)
  ) u_array (
    .mclk(mclk),
    .idx(arr_idx),
    .we_hi(arr_we && wr_hi),
    .we_lo(arr_we && wr_lo),
    .wdata(cur_wd),
    .rdata(arr_rd)
  );

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      tc_rd_d1_q <= 1'b0;
      tc_q <= '0;
    end
    else
    begin
      tc_rd_d1_q <= emul_mode && tc_req.rd;
      tc_q.valid <= tc_rd_d1_q && emul_mode;
      if (tc_rd_d1_q && emul_mode)
      begin
        tc_q.data <= arr_rd;
      end
    end
  end

  assign tc_rsp = tc_q;

endmodule // srm_standby_ram
`default_nettype wire
